/* rtl/mfp_map.svh */
// constants for the multifunction pin mux
`ifndef MFP_MAP_SVH
`define MFP_MAP_SVH
`define MFP_NPINS         10
`define MFP_PIN_IO1       4'h0
`define MFP_PIN_IO2       4'h1
`define MFP_PIN_IO3       4'h2
`define MFP_PIN_IO4       4'h3
`define MFP_PIN_IO5       4'h4
`define MFP_PIN_IO6       4'h5
`define MFP_PIN_TXD       4'h6
`define MFP_PIN_RXD       4'h7
`define MFP_PIN_BCLK      4'h8
`define MFP_PIN_WA        4'h9
`define MFP_CLK_HZ        100000000
`define MFP_MCLK13_HZ     13000000
`define MFP_MCLK26_HZ     26000000
`define MFP_MCLK13_DIV    (`MFP_CLK_HZ / (2 * `MFP_MCLK13_HZ))
`define MFP_MCLK26_DIV    (`MFP_CLK_HZ / (2 * `MFP_MCLK26_HZ))
`define MFP_WA_HALF       5'h0F
`define MFP_BCLK_DIV      8'h1F
`define MFP_BLINK_BITS    24
`endif

/* rtl/mfp_pkg.sv */
// types for the multifunction pin mux
package mfp_pkg;
  typedef enum logic [3:0] {
    MFP_DISABLED = 4'h0,
    MFP_GP_IN    = 4'h1,
    MFP_GP_OUT   = 4'h2,
    MFP_NET_STAT = 4'h3,
    MFP_GNSS_EN  = 4'h4,
    MFP_GNSS_RDY = 4'h5,
    MFP_RTC_SHR  = 4'h6,
    MFP_SIM_DET  = 4'h7,
    MFP_SIM_HOT  = 4'h8,
    MFP_AUDIO    = 4'h9,
    MFP_MCLK     = 4'hA
  } mfp_func_e;
  typedef enum logic [1:0] {
    MFP_NS_NONE = 2'h0,
    MFP_NS_HOME = 2'h1,
    MFP_NS_ROAM = 2'h2,
    MFP_NS_DATA = 2'h3
  } mfp_net_e;
  typedef struct packed {
    logic       valid;
    logic [3:0] pin;
    mfp_func_e  func;
  } mfp_sel_s;
  typedef struct packed {
    logic [9:0] out;
    logic [9:0] oe;
    logic [9:0] pd;
  } mfp_pad_s;
endpackage

/* rtl/mfp_audio_frame.sv */
// audio bit clock and word-alignment generator, long-sync frames
`timescale 1ns/10ps
`include "mfp_map.svh"
module mfp_audio_frame
  import mfp_pkg::*;
(
  input  wire logic clk,      // system clock
  input  wire logic rst_n,    // async reset
  input  wire logic enable,   // audio function active
  output logic      bclk_r,   // bit clock
  output logic      wa_r,     // word alignment
  output logic      fall_r    // pulse on bit clock falling edge
);
  logic [7:0] div_r;
  logic [4:0] bit_r;
  wire        tick = (div_r == `MFP_BCLK_DIV);

  // divider: one tick per half bit period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) div_r <= 8'h00;
    else if (!enable || tick) div_r <= 8'h00;
    else div_r <= div_r + 8'h01;
  end

  // 32 bit clocks per frame, alignment high 16 then low 16
  // alignment idles high so the first frame after enable is full length
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_r <= 1'b0;
      bit_r  <= 5'h00;
      wa_r   <= 1'b1;
      fall_r <= 1'b0;
    end else if (!enable) begin
      bclk_r <= 1'b0;
      bit_r  <= 5'h00;
      wa_r   <= 1'b1;
      fall_r <= 1'b0;
    end else begin
      fall_r <= tick && bclk_r;
      if (tick) begin
        bclk_r <= ~bclk_r;
        if (bclk_r) begin
          bit_r <= bit_r + 5'h01;
          wa_r  <= (bit_r + 5'h01) <= `MFP_WA_HALF;
        end
      end
    end
  end
endmodule

/* rtl/mfp_pin_mux.sv */
// ten-pin function multiplexer with custom pin functions
`timescale 1ns/10ps
`include "mfp_map.svh"
// Operation
// - ten pins, each input, output or function
// - network status shown on pins one-four
// - gnss supply enable on pins one-four
// - gnss ready sense only on pin three
// - rtc sharing output only on pin four
// - sim detect on pin five, default
// - hot plug enables sim on insertion
// - 13/26 MHz select on pin six, default; gives about 16.7/50 MHz
// - general input reports sensed level
// - general output drives level; pin four default
// - disabled means tristate, pull-down; pins 1-3
// - long-sync alignment 16 high, 16 low
module mfp_pin_mux
  import mfp_pkg::*;
(
  input  wire logic       REF_CLK,       // 100 MHz clock
  input  wire logic       RST_N,         // async reset, low
  input  wire mfp_sel_s   SEL,           // function select command
  input  wire logic [9:0] GP_LEVEL,      // general output levels
  input  wire mfp_net_e   NET_STATE,     // network state
  input  wire logic       GNSS_PWR,      // gnss supply request
  input  wire logic       RTC_SYNC,      // rtc sync level to share
  input  wire logic       MCLK_26,       // 1 selects 26 MHz
  input  wire logic       AUD_TXD,       // audio transmit data
  input  wire logic [9:0] PAD_IN,        // pad input levels
  output mfp_pad_s        PAD,           // pad drive, enable, pulldown
  output logic [9:0]      GP_IN_LEVEL,   // synchronised input levels
  output logic            SEL_ACK,       // selection accepted pulse
  output logic            SEL_REJ,       // selection refused pulse
  output logic            GNSS_READY,    // gnss data ready sensed
  output logic            SIM_PRESENT,   // sim card present
  output logic            SIM_IF_EN,     // sim interface enable
  output logic            AUD_RXD        // audio receive data
);
  mfp_func_e  func_r [0:9];
  logic [9:0] sync1_r;
  logic [9:0] sync2_r;
  logic [7:0] mdiv_r;
  logic       mclk_r;
  logic [`MFP_BLINK_BITS-1:0] blink_r;
  logic       bclk;
  logic       wa;
  logic       afall;
  logic       txd_r;
  mfp_pad_s   pad_nxt;

  // which functions a pin may carry
  function automatic logic allowed(input logic [3:0] p, input mfp_func_e f);
    case (f)
      MFP_DISABLED, MFP_GP_IN, MFP_GP_OUT: allowed = p < `MFP_NPINS;
      MFP_NET_STAT, MFP_GNSS_EN: allowed = p <= `MFP_PIN_IO4;
      MFP_GNSS_RDY: allowed = p == `MFP_PIN_IO3;
      MFP_RTC_SHR:  allowed = p == `MFP_PIN_IO4;
      MFP_SIM_DET, MFP_SIM_HOT: allowed = p == `MFP_PIN_IO5;
      MFP_MCLK:     allowed = p == `MFP_PIN_IO6;
      MFP_AUDIO:    allowed = p >= `MFP_PIN_TXD && p < `MFP_NPINS;
      default:      allowed = 1'b0;
    endcase
  endfunction

  // power-up function of each pin
  function automatic mfp_func_e reset_func(input int i);
    if (i <= `MFP_PIN_IO3) reset_func = MFP_DISABLED;
    else if (i == `MFP_PIN_IO4) reset_func = MFP_GP_OUT;
    else if (i == `MFP_PIN_IO5) reset_func = MFP_SIM_DET;
    else if (i == `MFP_PIN_IO6) reset_func = MFP_MCLK;
    else reset_func = MFP_AUDIO;
  endfunction

  // a command is taken only where the pin supports the function;
  // a refused one leaves the stored function untouched
  wire sel_ok = SEL.valid && allowed(SEL.pin, SEL.func);

  // one function register per pin; a write replaces it whole
  genvar g;
  generate
    for (g = 0; g < `MFP_NPINS; g++) begin : g_func
      always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) func_r[g] <= reset_func(g);
        else if (sel_ok && SEL.pin == 4'(g)) func_r[g] <= SEL.func;
      end
    end
  endgenerate

  // command answer pulses
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SEL_ACK <= 1'b0;
      SEL_REJ <= 1'b0;
    end else begin
      SEL_ACK <= sel_ok;
      SEL_REJ <= SEL.valid && !sel_ok;
    end
  end

  // pad inputs are asynchronous: two flops before use
  // the first stage may go metastable, so only the second is read
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_r <= 10'h000;
      sync2_r <= 10'h000;
    end else begin
      sync1_r <= PAD_IN;
      sync2_r <= sync1_r;
    end
  end

  // master clock: integer divider of the system clock, so 26 MHz comes
  // out as 50 MHz and 13 MHz as about 16.7 MHz; exact rates need a
  // faster source clock (limitation)
  wire [7:0] mdiv_lim = MCLK_26 ? 8'(`MFP_MCLK26_DIV - 1)
                                : 8'(`MFP_MCLK13_DIV - 1);
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mdiv_r <= 8'h00;
      mclk_r <= 1'b0;
    end else if (mdiv_r >= mdiv_lim) begin
      mdiv_r <= 8'h00;
      mclk_r <= ~mclk_r;
    end else begin
      mdiv_r <= mdiv_r + 8'h01;
    end
  end

  // free-running blink counter for network status patterns
  // a long counter trades flops for blink rates a person can see
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) blink_r <= '0;
    else blink_r <= blink_r + 1'b1;
  end

  // status pattern: off, steady, slow blink, fast blink
  wire b_slow = blink_r[`MFP_BLINK_BITS-1];
  wire b_fast = blink_r[`MFP_BLINK_BITS-3];
  wire net_lvl = (NET_STATE == MFP_NS_HOME) ? 1'b1 :
                 (NET_STATE == MFP_NS_ROAM) ? b_slow :
                 (NET_STATE == MFP_NS_DATA) ? b_fast : 1'b0;

  // audio engine runs only while the word-align pin carries audio
  mfp_audio_frame u_aud (
    .clk    (REF_CLK),
    .rst_n  (RST_N),
    .enable (func_r[`MFP_PIN_WA] == MFP_AUDIO),
    .bclk_r (bclk),
    .wa_r   (wa),
    .fall_r (afall)
  );

  // transmit data changes on bit clock fall
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) txd_r <= 1'b0;
    else if (afall) txd_r <= AUD_TXD;
  end

  // per-pin drive selection
  // sensing pins leave oe low; only disabled pins get the pull-down
  always_comb begin
    pad_nxt = '0;
    for (int i = 0; i < `MFP_NPINS; i++) begin
      case (func_r[i])
        MFP_GP_OUT: begin
          pad_nxt.out[i] = GP_LEVEL[i];
          pad_nxt.oe[i]  = 1'b1;
        end
        MFP_NET_STAT: begin
          pad_nxt.out[i] = net_lvl;
          pad_nxt.oe[i]  = 1'b1;
        end
        MFP_GNSS_EN: begin
          pad_nxt.out[i] = GNSS_PWR;
          pad_nxt.oe[i]  = 1'b1;
        end
        MFP_RTC_SHR: begin
          pad_nxt.out[i] = RTC_SYNC;
          pad_nxt.oe[i]  = 1'b1;
        end
        MFP_MCLK: begin
          pad_nxt.out[i] = mclk_r;
          pad_nxt.oe[i]  = 1'b1;
        end
        MFP_AUDIO: begin
          pad_nxt.oe[i]  = (i != `MFP_PIN_RXD);
          pad_nxt.out[i] = (i == `MFP_PIN_TXD) ? txd_r :
                           (i == `MFP_PIN_BCLK) ? bclk : wa;
        end
        MFP_DISABLED: pad_nxt.pd[i] = 1'b1;
        default: ;
      endcase
    end
  end

  // sim pad level is taken only after the two-flop synchroniser
  wire sim_lvl = sync2_r[`MFP_PIN_IO5];
  wire sim_det = func_r[`MFP_PIN_IO5] == MFP_SIM_DET;
  wire sim_hot = func_r[`MFP_PIN_IO5] == MFP_SIM_HOT;

  // registered outputs
  // a sensed input reads zero unless its pin carries that function
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PAD         <= '0;
      GP_IN_LEVEL <= 10'h000;
      GNSS_READY  <= 1'b0;
      SIM_PRESENT <= 1'b0;
      SIM_IF_EN   <= 1'b1;
      AUD_RXD     <= 1'b0;
    end else begin
      PAD <= pad_nxt;
      for (int i = 0; i < `MFP_NPINS; i++)
        GP_IN_LEVEL[i] <= (func_r[i] == MFP_GP_IN) && sync2_r[i];
      GNSS_READY  <= (func_r[`MFP_PIN_IO3] == MFP_GNSS_RDY) &&
                     sync2_r[`MFP_PIN_IO3];
      SIM_PRESENT <= (sim_det || sim_hot) && sim_lvl;
      SIM_IF_EN   <= sim_hot ? sim_lvl : 1'b1;
      AUD_RXD     <= (func_r[`MFP_PIN_RXD] == MFP_AUDIO) &&
                     sync2_r[`MFP_PIN_RXD];
    end
  end
endmodule

/* tb/mfp_pin_mux_chk.sv */
// port assertions for the pin mux
`timescale 1ns/10ps
module mfp_pin_mux_chk
  import mfp_pkg::*;
(
  input wire logic     REF_CLK, // clock
  input wire logic     RST_N,   // reset, low
  input wire mfp_sel_s SEL,     // select command
  input wire mfp_pad_s PAD,     // pad drive
  input wire logic     SEL_ACK, // accept pulse
  input wire logic     SEL_REJ  // refuse pulse
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // command fields, named for short properties
  wire       v = SEL.valid;
  wire [3:0] p = SEL.pin;
  mfp_func_e f;
  assign f = SEL.func;

  a_one_answer: assert property (v |=> SEL_ACK != SEL_REJ)
    else $error("select not answered once");
  a_no_stray: assert property ((SEL_ACK || SEL_REJ) |-> $past(v))
    else $error("answer without command");
  a_rdy_pin: assert property (
    v && f == MFP_GNSS_RDY && p != 4'h2 |=> SEL_REJ)
    else $error("ready sense off pin three");
  a_rtc_pin: assert property (
    v && f == MFP_RTC_SHR && p != 4'h3 |=> SEL_REJ)
    else $error("rtc share off pin four");
  a_sim_pin: assert property (
    v && (f == MFP_SIM_DET || f == MFP_SIM_HOT) && p != 4'h4 |=> SEL_REJ)
    else $error("sim function off pin five");
  a_clk_pin: assert property (
    v && f == MFP_MCLK && p != 4'h5 |=> SEL_REJ)
    else $error("master clock off pin six");
  a_net_pins: assert property (
    v && (f == MFP_NET_STAT || f == MFP_GNSS_EN) && p > 4'h3 |=> SEL_REJ)
    else $error("status or supply above pin four");
  a_dis_pull: assert property (
    v && f == MFP_DISABLED && p < 4'hA |=> SEL_ACK
    ##1 (PAD.pd[$past(p, 2)] && !PAD.oe[$past(p, 2)]))
    else $error("disabled pin not pulled down");
endmodule
bind mfp_pin_mux mfp_pin_mux_chk i_mfp_pin_mux_chk (.REF_CLK(REF_CLK),
  .RST_N(RST_N), .SEL(SEL), .PAD(PAD), .SEL_ACK(SEL_ACK), .SEL_REJ(SEL_REJ));

/* tb/mfp_periph_model.sv */
// far side: gnss receiver, sim holder and board pads
`timescale 1ns/10ps
module mfp_periph_model
  import mfp_pkg::*;
(
  input  wire mfp_pad_s   pad,     // mux pad drive
  input  wire logic [9:0] ext_drv, // far side drives pad
  input  wire logic [9:0] ext_lvl, // far side level
  output logic [9:0]      pad_in   // resolved wire level
);
  // mux drive wins; an undriven pad reads low whether or not its pd bit is set
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      pad_in[i] = pad.oe[i] ? pad.out[i] : (ext_drv[i] & ext_lvl[i]);
    end
  end
endmodule

/* tb/mfp_pin_mux_tb.sv */
// self-checking bench for the pin mux
`timescale 1ns/10ps
module mfp_pin_mux_tb
  import mfp_pkg::*;
;
  logic clk = 0, rst_n = 0, gp_pwr = 0, rtc = 0, m26 = 1, aud_txd = 0;
  logic ack, rej, rdy, simp, simen, rxd;
  logic [9:0] lvl = 0, gp_in, pin, drv = 0, ext = 0;
  mfp_sel_s sel = '0;
  mfp_net_e net = MFP_NS_NONE;
  mfp_pad_s pad;
  int miscompares = 0, checks_done = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  mfp_pin_mux i_mfp_pin_mux (.REF_CLK(clk), .RST_N(rst_n), .SEL(sel),
    .GP_LEVEL(lvl), .NET_STATE(net), .GNSS_PWR(gp_pwr), .RTC_SYNC(rtc),
    .MCLK_26(m26), .AUD_TXD(aud_txd), .PAD_IN(pin), .PAD(pad),
    .GP_IN_LEVEL(gp_in), .SEL_ACK(ack), .SEL_REJ(rej), .GNSS_READY(rdy),
    .SIM_PRESENT(simp), .SIM_IF_EN(simen), .AUD_RXD(rxd));
  mfp_periph_model i_mfp_periph_model (.pad(pad), .ext_drv(drv),
    .ext_lvl(ext), .pad_in(pin));
  task automatic chk(input logic [9:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one-cycle command; answer next cycle, pad the cycle after
  task automatic pick(input logic [3:0] p, input mfp_func_e f, input logic ok);
    @(negedge clk) sel = '{1'b1, p, f};
    @(negedge clk) sel.valid = 1'b0;
    chk({ack, rej}, {ok, !ok}, "select answer");
    wt(1);
  endtask
  task automatic t_refuse;
    logic [3:0] pl[6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h5, 4'h0};
    mfp_func_e fl[6] = '{MFP_GNSS_RDY, MFP_RTC_SHR, MFP_MCLK, MFP_SIM_HOT,
                         MFP_NET_STAT, MFP_AUDIO};
    for (int i = 0; i < 6; i++) pick(pl[i], fl[i], 1'b0);
    chk(pad.oe, 10'h368, "refused select changed pads");
  endtask
  task automatic t_gpio;
    pick(4'h0, MFP_GP_OUT, 1'b1);
    lvl = 10'h001;
    wt(3);
    chk(pad.out[0] & pad.oe[0], 10'h001, "gp out high");
    lvl = 10'h000;
    wt(3);
    chk(pad.out[0], 10'h000, "gp out low");
    pick(4'h1, MFP_GP_IN, 1'b1);
    drv[1] = 1'b1;
    ext[1] = 1'b1;
    wt(4);
    chk(gp_in[1], 10'h001, "gp in level");
    ext[1] = 1'b0;
    wt(4);
    chk(gp_in[1], 10'h000, "gp in low");
    pick(4'h1, MFP_DISABLED, 1'b1);
    chk(pad.pd[1], 10'h001, "disabled pull-down");
  endtask
  task automatic t_func;
    pick(4'h1, MFP_GNSS_EN, 1'b1);
    gp_pwr = 1'b1;
    pick(4'h3, MFP_RTC_SHR, 1'b1);
    rtc = 1'b1;
    pick(4'h2, MFP_GNSS_RDY, 1'b1);
    {drv[2], ext[2]} = 2'b11;
    pick(4'h0, MFP_NET_STAT, 1'b1);
    net = MFP_NS_HOME;
    wt(4);
    chk(pad.out[3:0], 10'h00B, "gnss, rtc and status drive");
    chk(rdy, 10'h001, "gnss ready sense");
    net = MFP_NS_NONE;
    gp_pwr = 1'b0;
    wt(3);
    chk(pad.out[1:0], 10'h000, "status and supply off");
    {drv[4], ext[4]} = 2'b11;
    wt(4);
    chk({simp, simen}, 10'h003, "sim detect default");
    pick(4'h4, MFP_SIM_HOT, 1'b1);
    ext[4] = 1'b0;
    wt(4);
    chk({simp, simen}, 10'h000, "sim off on removal");
    ext[4] = 1'b1;
    wt(4);
    chk({simp, simen}, 10'h003, "sim on on insertion");
  endtask
  // counts master clock toggles, then bit clock and word-align edges
  task automatic t_clocks;
    int n, nb, nw;
    logic pb, pw;
    aud_txd = 1'b1;
    {drv[7], ext[7]} = 2'b11;
    for (int k = 0; k < 2; k++) begin
      m26 = !k[0];
      wt(8);
      n = 0;
      pb = pad.out[5];
      for (int i = 0; i < 60; i++) begin
        @(negedge clk);
        n += int'(pad.out[5] != pb);
        pb = pad.out[5];
      end
      chk(10'(n), k ? 10'd20 : 10'd60, "master clock rate");
    end
    n = 0;
    nb = 0;
    nw = 0;
    pb = pad.out[8];
    pw = pad.out[9];
    repeat (4096) begin
      @(negedge clk);
      n += int'(pad.out[9]);
      nb += int'(pad.out[8] != pb);
      nw += int'(pad.out[9] != pw);
      pb = pad.out[8];
      pw = pad.out[9];
    end
    chk(10'(n / 4), 10'd512, "word align duty");
    chk(10'(nb), 10'd128, "bit clock rate");
    chk(10'(nw), 10'd4, "word align frame");
    chk({rxd, pad.out[6]}, 10'h003, "audio data paths");
  endtask
  task automatic finish_test;
    $display("checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #300us;
    miscompares++;
    finish_test();
  end
  initial begin
    wt(10);
    rst_n = 1;
    wt(2);
    chk(pad.pd, 10'h007, "reset pull-downs");
    chk(pad.oe, 10'h368, "reset drivers");
    chk(simen, 1, "reset sim enable");
    t_refuse();
    t_gpio();
    t_func();
    t_clocks();
    finish_test();
  end
endmodule
